// ===== common/wlbsu_pkg.sv
package wlbsu_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] SRC_OFS      = 8'h04;
    localparam logic [7:0] DST_OFS      = 8'h08;
    localparam logic [7:0] CNT_OFS      = 8'h0C;
    localparam logic [7:0] DATA_OFS     = 8'h10;
    localparam logic [7:0] FLAGS_OFS    = 8'h14;
    localparam logic [7:0] ERRCODE_OFS  = 8'h18;
    localparam logic [7:0] IRQSTAT_OFS  = 8'h1C;
    localparam logic [7:0] IRQMASK_OFS  = 8'h20;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_PULSE_BIT = 1;
    localparam int CTRL_OP_LSB    = 2;
    localparam int FLG_GCARRY     = 0;
    localparam int FLG_MCARRY     = 1;
    localparam int FLG_BORROW     = 2;
    localparam int FLG_DIR        = 3;
    localparam int FLG_ERR        = 4;
    localparam int FLG_BUSY       = 8;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ERR_BIT    = 1;

    // ----------------------------------------
    // Operation codes and reset values
    // ----------------------------------------
    localparam logic [1:0] OP_LIST_INSERT = 2'h0;
    localparam logic [1:0] OP_MATRIX      = 2'h1;
    localparam logic [1:0] OP_WORD_RIGHT  = 2'h2;
    localparam logic [1:0] OP_WORD_LEFT   = 2'h3;
    localparam logic [15:0] REG_RESET     = 16'h0000;

    // ----------------------------------------
    // Limits and error codes
    // ----------------------------------------
    localparam logic [15:0] ERR_RANGE     = 16'h2003;
    localparam logic [15:0] ERR_OPERAND   = 16'h200B;
    localparam logic [15:0] LIST_MAX      = 16'h7FFF;
    localparam logic [15:0] MX_MAX_ROWS   = 16'h0100;
    localparam logic [15:0] WSH_MAX_BITS  = 16'h0010;
    localparam logic [16:0] DEV_LAST_ADDR = 17'h03FFF;

endpackage

// ===== core/wlbsu_core.sv
// How it works
// - Insert moves entries n..length up one word, writes the data word at n, adds one to length.
// - A full list of length 32767 takes no insert and sets the general carry flag instead (the code aborts with 2003 first, as base+length+1 is past the range).
// - Negative length or base+n or base+length+1 past the device range aborts with code 2003.
// - Insert position above the length or negative aborts with code 200B.
// - Matrix shift treats n rows as one bit string, left with direction clear, right when set.
// - The vacated bit takes the borrow flag, the last bit out goes to the matrix carry flag.
// - Matrix row count outside 1..256 aborts with code 200B.
// - Last source or destination row past the device range aborts with code 2003.
// - Word right shift zero-fills the top n bits and carries original bit n-1.
// - Word right shift count negative or above 16 aborts with code 200B.
// - Word left shift zero-fills the low n bits and carries original bit 16-n.
// - Word left shift count negative or above 16 aborts with code 200B.
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module wlbsu_core (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    input  wire logic [15:0] mem_rdata
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_LEN_WAIT, ST_LEN_USE, ST_INS_RD, ST_INS_WAIT, ST_INS_MOVE,
        ST_INS_DATA, ST_INS_LEN, ST_MX_RD, ST_MX_WAIT, ST_MX_USE, ST_WS_WAIT,
        ST_WS_USE
    } wlbsu_state_type;

    // ----------------------------------------
    // Register file state
    // ----------------------------------------
    logic [3:0]  ctrl_r, ctrl_nxt;
    logic [15:0] src_r, src_nxt, dst_r, dst_nxt, cnt_r, cnt_nxt, data_r, data_nxt;
    logic [4:0]  flags_r, flags_nxt;
    logic [15:0] errc_r, errc_nxt;
    logic [1:0]  istat_r, istat_nxt, imask_r, imask_nxt;
    logic        ack_r, ack_nxt, irq_r, irq_nxt;
    logic [31:0] rd_r, rd_nxt;

    // ----------------------------------------
    // Engine state
    // ----------------------------------------
    wlbsu_state_type state_r, state_nxt;
    logic [1:0]  op_r, op_nxt;
    logic [15:0] idx_r, idx_nxt, len_r, len_nxt;
    logic        cin_r, cin_nxt, dir_r, dir_nxt, enp_r, enp_nxt;
    logic [15:0] maddr_r, maddr_nxt, mwd_r, mwd_nxt;
    logic        mwe_r, mwe_nxt, mre_r, mre_nxt;

    logic        ev_done, ev_err, gc_en, gc_val, mc_en, mc_val;
    logic [15:0] err_val, row_out;
    logic        row_co;
    logic [31:0] rsh, lsh;
    logic [16:0] src17, dst17, cnt17, len17;
    logic        busy, wr_acc, rd_acc;
    logic [15:0] wmask;

    assign busy   = state_r != ST_IDLE;
    assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign rd_acc = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
    assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign src17  = {1'b0, src_r};
    assign dst17  = {1'b0, dst_r};
    assign cnt17  = {1'b0, cnt_r};
    assign len17  = {1'b0, mem_rdata};
    assign rsh    = {mem_rdata, 16'h0000} >> cnt_r[4:0];
    assign lsh    = {16'h0000, mem_rdata} << cnt_r[4:0];

    // ----------------------------------------
    // Register file and bus slave
    // ----------------------------------------
    always_comb begin
        ctrl_nxt  = ctrl_r;
        src_nxt   = src_r;
        dst_nxt   = dst_r;
        cnt_nxt   = cnt_r;
        data_nxt  = data_r;
        flags_nxt = flags_r;
        errc_nxt  = errc_r;
        istat_nxt = istat_r;
        imask_nxt = imask_r;
        ack_nxt   = wb_cyc_i && wb_stb_i && !ack_r;
        rd_nxt    = 32'h0000_0000;
        // Operands and shift flags are frozen while an operation runs
        if (wr_acc) begin
            unique case (wb_adr_i)
                wlbsu_pkg::CTRL_OFS:
                    if (wb_sel_i[0]) ctrl_nxt = wb_dat_i[3:0];
                wlbsu_pkg::SRC_OFS:
                    if (!busy) src_nxt = (src_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                wlbsu_pkg::DST_OFS:
                    if (!busy) dst_nxt = (dst_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                wlbsu_pkg::CNT_OFS:
                    if (!busy) cnt_nxt = (cnt_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                wlbsu_pkg::DATA_OFS:
                    if (!busy) data_nxt = (data_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                wlbsu_pkg::FLAGS_OFS:
                    if (!busy && wb_sel_i[0]) flags_nxt = wb_dat_i[4:0];
                wlbsu_pkg::IRQSTAT_OFS:
                    if (wb_sel_i[0]) istat_nxt = istat_r & ~wb_dat_i[1:0];
                wlbsu_pkg::IRQMASK_OFS:
                    if (wb_sel_i[0]) imask_nxt = wb_dat_i[1:0];
                default: ;
            endcase
        end
        if (rd_acc) begin
            unique case (wb_adr_i)
                wlbsu_pkg::CTRL_OFS:    rd_nxt = {28'h0000000, ctrl_r};
                wlbsu_pkg::SRC_OFS:     rd_nxt = {16'h0000, src_r};
                wlbsu_pkg::DST_OFS:     rd_nxt = {16'h0000, dst_r};
                wlbsu_pkg::CNT_OFS:     rd_nxt = {16'h0000, cnt_r};
                wlbsu_pkg::DATA_OFS:    rd_nxt = {16'h0000, data_r};
                wlbsu_pkg::FLAGS_OFS:   rd_nxt = {23'h000000, busy, 3'h0, flags_r};
                wlbsu_pkg::ERRCODE_OFS: rd_nxt = {16'h0000, errc_r};
                wlbsu_pkg::IRQSTAT_OFS: rd_nxt = {30'h00000000, istat_r};
                wlbsu_pkg::IRQMASK_OFS: rd_nxt = {30'h00000000, imask_r};
                default:                rd_nxt = 32'h0000_0000;
            endcase
        end
        // Hardware updates come last so an event beats a same-cycle clear
        if (gc_en) flags_nxt[wlbsu_pkg::FLG_GCARRY] = gc_val;
        if (mc_en) flags_nxt[wlbsu_pkg::FLG_MCARRY] = mc_val;
        if (ev_err) begin
            flags_nxt[wlbsu_pkg::FLG_ERR]     = 1'b1;
            errc_nxt                           = err_val;
            istat_nxt[wlbsu_pkg::IRQ_ERR_BIT] = 1'b1;
        end
        if (ev_done) istat_nxt[wlbsu_pkg::IRQ_DONE_BIT] = 1'b1;
        irq_nxt = |(istat_r & imask_r);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_r  <= 4'h0;
            src_r   <= wlbsu_pkg::REG_RESET;
            dst_r   <= wlbsu_pkg::REG_RESET;
            cnt_r   <= wlbsu_pkg::REG_RESET;
            data_r  <= wlbsu_pkg::REG_RESET;
            flags_r <= 5'h00;
            errc_r  <= wlbsu_pkg::REG_RESET;
            istat_r <= 2'h0;
            imask_r <= 2'h0;
            ack_r   <= 1'b0;
            irq_r   <= 1'b0;
            rd_r    <= 32'h0000_0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            src_r   <= src_nxt;
            dst_r   <= dst_nxt;
            cnt_r   <= cnt_nxt;
            data_r  <= data_nxt;
            flags_r <= flags_nxt;
            errc_r  <= errc_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            ack_r   <= ack_nxt;
            irq_r   <= irq_nxt;
            rd_r    <= rd_nxt;
        end
    end

    // ----------------------------------------
    // Execution engine
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        idx_nxt   = idx_r;
        len_nxt   = len_r;
        cin_nxt   = cin_r;
        dir_nxt   = dir_r;
        enp_nxt   = enp_r;
        maddr_nxt = maddr_r;
        mwd_nxt   = mwd_r;
        mwe_nxt   = 1'b0;
        mre_nxt   = 1'b0;
        ev_done   = 1'b0;
        ev_err    = 1'b0;
        err_val   = wlbsu_pkg::ERR_RANGE;
        gc_en     = 1'b0;
        gc_val    = 1'b0;
        mc_en     = 1'b0;
        mc_val    = 1'b0;
        row_out   = dir_r ? {cin_r, mem_rdata[15:1]} : {mem_rdata[14:0], cin_r};
        row_co    = dir_r ? mem_rdata[0] : mem_rdata[15];
        unique case (state_r)
            ST_IDLE: begin
                // Edge memory only advances while idle, so a fall and rise during a run is not seen
                enp_nxt = ctrl_r[wlbsu_pkg::CTRL_EN_BIT];
                if (ctrl_r[wlbsu_pkg::CTRL_EN_BIT]
                    && (!ctrl_r[wlbsu_pkg::CTRL_PULSE_BIT] || !enp_r)) begin
                    op_nxt = ctrl_r[wlbsu_pkg::CTRL_OP_LSB +: 2];
                    unique case (ctrl_r[wlbsu_pkg::CTRL_OP_LSB +: 2])
                        wlbsu_pkg::OP_LIST_INSERT: begin
                            maddr_nxt = src_r;
                            mre_nxt   = 1'b1;
                            state_nxt = ST_LEN_WAIT;
                        end
                        wlbsu_pkg::OP_MATRIX: begin
                            if (cnt_r[15] || cnt_r == 16'h0000
                                || cnt_r > wlbsu_pkg::MX_MAX_ROWS) begin
                                ev_err  = 1'b1;
                                err_val = wlbsu_pkg::ERR_OPERAND;
                            end else if (src17 + cnt17 - 17'h00001 > wlbsu_pkg::DEV_LAST_ADDR
                                || dst17 + cnt17 - 17'h00001 > wlbsu_pkg::DEV_LAST_ADDR) begin
                                ev_err = 1'b1;
                            end else begin
                                dir_nxt   = flags_r[wlbsu_pkg::FLG_DIR];
                                idx_nxt   = flags_r[wlbsu_pkg::FLG_DIR] ? cnt_r - 16'h0001
                                                                        : 16'h0000;
                                len_nxt   = cnt_r;
                                cin_nxt   = flags_r[wlbsu_pkg::FLG_BORROW];
                                state_nxt = ST_MX_RD;
                            end
                        end
                        default: begin
                            if (cnt_r[15] || cnt_r > wlbsu_pkg::WSH_MAX_BITS) begin
                                ev_err  = 1'b1;
                                err_val = wlbsu_pkg::ERR_OPERAND;
                            end else if (cnt_r == 16'h0000) begin
                                ev_done = 1'b1;
                            end else begin
                                maddr_nxt = dst_r;
                                mre_nxt   = 1'b1;
                                state_nxt = ST_WS_WAIT;
                            end
                        end
                    endcase
                end
            end
            ST_LEN_WAIT: state_nxt = ST_LEN_USE;
            ST_LEN_USE: begin
                state_nxt = ST_IDLE;
                if (mem_rdata[15]) begin
                    ev_err = 1'b1;
                end else if (cnt_r[15]) begin
                    ev_err  = 1'b1;
                    err_val = wlbsu_pkg::ERR_OPERAND;
                end else if (src17 + cnt17 > wlbsu_pkg::DEV_LAST_ADDR
                    || src17 + len17 + 17'h00001 > wlbsu_pkg::DEV_LAST_ADDR) begin
                    ev_err = 1'b1;
                end else if (cnt_r > mem_rdata) begin
                    ev_err  = 1'b1;
                    err_val = wlbsu_pkg::ERR_OPERAND;
                end else if (mem_rdata == wlbsu_pkg::LIST_MAX) begin
                    gc_en   = 1'b1;
                    gc_val  = 1'b1;
                    ev_done = 1'b1;
                end else begin
                    idx_nxt   = mem_rdata;
                    len_nxt   = mem_rdata;
                    state_nxt = ST_INS_RD;
                end
            end
            ST_INS_RD: begin
                // Top entry first, so no entry is overwritten before it is moved
                maddr_nxt = src_r + idx_r;
                mre_nxt   = 1'b1;
                state_nxt = ST_INS_WAIT;
            end
            ST_INS_WAIT: state_nxt = ST_INS_MOVE;
            ST_INS_MOVE: begin
                maddr_nxt = src_r + idx_r + 16'h0001;
                mwd_nxt   = mem_rdata;
                mwe_nxt   = 1'b1;
                idx_nxt   = idx_r - 16'h0001;
                state_nxt = (idx_r == cnt_r) ? ST_INS_DATA : ST_INS_RD;
            end
            ST_INS_DATA: begin
                maddr_nxt = src_r + cnt_r;
                mwd_nxt   = data_r;
                mwe_nxt   = 1'b1;
                state_nxt = ST_INS_LEN;
            end
            ST_INS_LEN: begin
                maddr_nxt = src_r;
                mwd_nxt   = len_r + 16'h0001;
                mwe_nxt   = 1'b1;
                ev_done   = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_MX_RD: begin
                maddr_nxt = src_r + idx_r;
                mre_nxt   = 1'b1;
                state_nxt = ST_MX_WAIT;
            end
            ST_MX_WAIT: state_nxt = ST_MX_USE;
            ST_MX_USE: begin
                maddr_nxt = dst_r + idx_r;
                mwd_nxt   = row_out;
                mwe_nxt   = 1'b1;
                cin_nxt   = row_co;
                len_nxt   = len_r - 16'h0001;
                idx_nxt   = dir_r ? idx_r - 16'h0001 : idx_r + 16'h0001;
                if (len_r == 16'h0001) begin
                    mc_en     = 1'b1;
                    mc_val    = row_co;
                    ev_done   = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    state_nxt = ST_MX_RD;
                end
            end
            ST_WS_WAIT: state_nxt = ST_WS_USE;
            ST_WS_USE: begin
                maddr_nxt = dst_r;
                mwe_nxt   = 1'b1;
                gc_en     = 1'b1;
                if (op_r == wlbsu_pkg::OP_WORD_RIGHT) begin
                    mwd_nxt = rsh[31:16];
                    gc_val  = rsh[15];
                end else begin
                    mwd_nxt = lsh[15:0];
                    gc_val  = lsh[16];
                end
                ev_done   = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            op_r    <= 2'h0;
            idx_r   <= 16'h0000;
            len_r   <= 16'h0000;
            cin_r   <= 1'b0;
            dir_r   <= 1'b0;
            enp_r   <= 1'b0;
            maddr_r <= 16'h0000;
            mwd_r   <= 16'h0000;
            mwe_r   <= 1'b0;
            mre_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            idx_r   <= idx_nxt;
            len_r   <= len_nxt;
            cin_r   <= cin_nxt;
            dir_r   <= dir_nxt;
            enp_r   <= enp_nxt;
            maddr_r <= maddr_nxt;
            mwd_r   <= mwd_nxt;
            mwe_r   <= mwe_nxt;
            mre_r   <= mre_nxt;
        end
    end

    assign wb_dat_o  = rd_r;
    assign wb_ack_o  = ack_r;
    assign irq       = irq_r;
    assign mem_addr  = maddr_r;
    assign mem_wdata = mwd_r;
    assign mem_we    = mwe_r;
    assign mem_re    = mre_r;

endmodule

`default_nettype wire

// ===== test/wlbsu_core_sva.sv
`timescale 1ns/1ps
`default_nettype none

module wlbsu_core_sva (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic [15:0] mem_rdata
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("data without ack");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper bits set");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i[7:2] > 6'h08 |=> wb_ack_o && wb_dat_o == 32'h00000000)
        else $error("bad unmapped read");
    a_write_range: assert property (mem_we |-> {1'b0, mem_addr} <= wlbsu_pkg::DEV_LAST_ADDR)
        else $error("write out of range");
    a_read_range: assert property (mem_re |-> {1'b0, mem_addr} <= wlbsu_pkg::DEV_LAST_ADDR)
        else $error("read out of range");
    a_strobe_excl: assert property (!(mem_we && mem_re))
        else $error("read with write");
    a_re_pulse: assert property (mem_re |=> !mem_re)
        else $error("read strobe too long");
    a_quiet_reset: assert property ($past(rst) |-> !mem_we && !mem_re && !irq && !wb_ack_o)
        else $error("active after reset");

    c_mem_write: cover property (mem_we);
    c_irq_rise: cover property ($rose(irq));
    c_read_ack: cover property (wb_ack_o && !wb_we_i);
endmodule

bind wlbsu_core wlbsu_core_sva u_wlbsu_core_sva (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
);

`default_nettype wire

// ===== test/wlbsu_mem.sv
`timescale 1ns/1ps
`default_nettype none

module wlbsu_mem (
    input  wire logic        clock,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic      [15:0] mem_rdata
);
    logic [15:0] ram [0:16383];
    logic [15:0] rdata_r = 16'h0000;

    // Outside the one valid cycle the data toggles, so a late sample shows up
    always @(posedge clock) begin
        rdata_r <= mem_re ? ram[mem_addr[13:0]] : ~rdata_r;
        if (mem_we) begin
            ram[mem_addr[13:0]] <= mem_wdata;
        end
    end

    assign mem_rdata = rdata_r;
endmodule

`default_nettype wire

// ===== test/word_list_insert_and_bit_shift_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module word_list_insert_and_bit_shift_unit_tb;
    logic        clock    = 1'b0;
    logic        rst      = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic        mem_we;
    logic        mem_re;
    logic [15:0] mem_rdata;
    logic [31:0] seed_r   = 32'h1BC7;
    logic [31:0] rd;
    int          errors   = 0;
    int          check_count = 0;
    int          exp_mem [16384];
    int          exp_code = 0;
    int          cnts [6] = '{1, 6, 16, 0, 17, -1};
    int          lst      = int'(wlbsu_pkg::DEV_LAST_ADDR);

    always #10 clock = ~clock;

    wlbsu_core u_wlbsu_core (
        .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
    );
    wlbsu_mem u_wlbsu_mem (
        .clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] next_rand();
        seed_r = seed_r ^ (seed_r << 13);
        seed_r = seed_r ^ (seed_r >> 17);
        seed_r = seed_r ^ (seed_r << 5);
        return seed_r;
    endfunction

    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t register got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_mem(input int a);
        check_count++;
        if (u_wlbsu_mem.ram[a] !== exp_mem[a][15:0]) begin
            errors++;
            $display("MISMATCH t=%0t word %0d got %h", $time, a, u_wlbsu_mem.ram[a]);
        end
    endtask

    // Classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("MISMATCH t=%0t no acknowledge", $time);
            final_report();
        end
    endtask

    // ----------------------------------------
    // One operation: load, model, run, compare
    // ----------------------------------------
    task automatic run(input int op, s, d, n, dir, brw, len, msk);
        int i, c, r, dat, code, gc, mc;
        for (i = 0; i < 16384; i++) begin
            exp_mem[i] = int'(next_rand() & 16'hFFFF);
            u_wlbsu_mem.ram[i] = exp_mem[i][15:0];
        end
        if (op == 0) begin
            exp_mem[s] = len & 16'hFFFF;
            u_wlbsu_mem.ram[s] = len[15:0];
        end
        dat = int'(next_rand() & 16'hFFFF);
        code = 0;
        gc = 0;
        mc = 0;
        wb(1'b1, wlbsu_pkg::SRC_OFS, s);
        wb(1'b1, wlbsu_pkg::DST_OFS, d);
        wb(1'b1, wlbsu_pkg::CNT_OFS, n & 16'hFFFF);
        wb(1'b1, wlbsu_pkg::DATA_OFS, dat);
        wb(1'b1, wlbsu_pkg::FLAGS_OFS, dir * 8 + brw * 4);
        wb(1'b1, wlbsu_pkg::IRQSTAT_OFS, 32'h3);
        wb(1'b1, wlbsu_pkg::IRQMASK_OFS, msk);
        case (op)
            0: begin
                if (len < 0) code = 16'h2003;
                else if (n < 0) code = 16'h200B;
                else if (s + n > lst || s + len + 1 > lst) code = 16'h2003;
                else if (n > len) code = 16'h200B;
                else if (len == 32767) gc = 1;
                else begin
                    for (i = len; i >= n; i--) exp_mem[s + i + 1] = exp_mem[s + i];
                    exp_mem[s + n] = dat;
                    exp_mem[s] = len + 1;
                end
            end
            1: begin
                if (n < 1 || n > 256) code = 16'h200B;
                else if (s + n - 1 > lst || d + n - 1 > lst) code = 16'h2003;
                else begin
                    c = brw;
                    for (i = 0; i < n; i++) begin
                        r = exp_mem[dir ? s + n - 1 - i : s + i];
                        exp_mem[dir ? d + n - 1 - i : d + i] =
                            dir ? (c << 15) | (r >> 1) : ((r << 1) & 16'hFFFF) | c;
                        c = dir ? r & 1 : (r >> 15) & 1;
                    end
                    mc = c;
                end
            end
            default: begin
                r = exp_mem[d];
                if (n < 0 || n > 16) code = 16'h200B;
                else if (n > 0) begin
                    gc = (r >> (op == 2 ? n - 1 : 16 - n)) & 1;
                    exp_mem[d] = op == 2 ? r >> n : (r << n) & 16'hFFFF;
                end
            end
        endcase
        wb(1'b1, wlbsu_pkg::CTRL_OFS, (code != 0 && op > 0 ? 1 : 3) + op * 4);
        for (i = 0; i < 600; i++) begin
            wb(1'b0, wlbsu_pkg::FLAGS_OFS, 32'h0);
            if (rd[8] === 1'b0) break;
        end
        if (i == 600) begin
            errors++;
            $display("MISMATCH t=%0t engine stays busy", $time);
            final_report();
        end
        // Enable held high: a pulse run must not repeat
        repeat (30) @(posedge clock);
        wb(1'b1, wlbsu_pkg::CTRL_OFS, 32'h0);
        if (code != 0) exp_code = code;
        wb(1'b0, wlbsu_pkg::FLAGS_OFS, 32'h0);
        cmp_reg(rd & 32'h1F, (code != 0) * 16 + dir * 8 + brw * 4 + mc * 2 + gc);
        wb(1'b0, wlbsu_pkg::ERRCODE_OFS, 32'h0);
        cmp_reg(rd, exp_code);
        wb(1'b0, wlbsu_pkg::IRQSTAT_OFS, 32'h0);
        cmp_reg(rd & 3, code != 0 ? 2 : 1);
        cmp_reg({31'h0, irq}, ((code != 0 ? 2 : 1) & msk) != 0);
        for (i = 0; i < 16384; i++) cmp_mem(i);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        wb(1'b0, 8'h24, 32'h0);
        cmp_reg(rd, 32'h0);
        run(0, 256, 0, 4, 0, 0, 8, 1);
        run(0, 256, 0, 8, 0, 0, 8, 1);
        run(0, 256, 0, 1, 0, 0, 0, 2);
        run(0, 256, 0, 9, 0, 0, 8, 2);
        run(0, 256, 0, -1, 0, 0, 8, 2);
        run(0, 256, 0, 2, 0, 0, -1, 2);
        run(0, 16376, 0, 4, 0, 0, 8, 2);
        run(0, 512, 0, 4, 0, 0, 32767, 2);
        run(1, 768, 1024, 3, 0, 0, 0, 1);
        run(1, 768, 1024, 3, 1, 1, 0, 1);
        run(1, 768, 1024, 1, 0, 1, 0, 1);
        run(1, 768, 1024, 256, 1, 0, 0, 1);
        run(1, 768, 1024, 0, 0, 0, 0, 2);
        run(1, 768, 1024, 257, 1, 1, 0, 2);
        run(1, 16382, 1024, 3, 0, 1, 0, 2);
        run(1, 768, 16383, 2, 1, 0, 0, 0);
        foreach (cnts[j]) begin
            run(2, 0, 2000, cnts[j], 0, 0, 0, cnts[j] < 0 || cnts[j] > 16 ? 2 : 1);
            run(3, 0, 2000, cnts[j], 0, 0, 0, cnts[j] < 0 || cnts[j] > 16 ? 2 : 1);
        end
        wb(1'b1, wlbsu_pkg::ERRCODE_OFS, 32'hFFFF);
        wb(1'b0, wlbsu_pkg::ERRCODE_OFS, 32'h0);
        cmp_reg(rd, exp_code);
        final_report();
    end
endmodule

`default_nettype wire
